// file: hdl/regfile_pkg.sv
// constants, commands and carriers for the cpu register file
package regfile_pkg;

  // ************************************************************
  // reset values and vector locations
  // ************************************************************
  localparam logic [15:0] SP_RESET     = 16'h00FF;
  localparam logic [7:0]  H_RESET      = 8'h00;
  localparam logic [7:0]  FLAGS_RESET  = 8'h68;
  localparam logic [7:0]  FLAGS_ONES   = 8'h60;
  localparam logic [15:0] VEC_HI_ADDR  = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR  = 16'hFFFF;

  // ************************************************************
  // condition flag bit positions
  // ************************************************************
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // ************************************************************
  // bus register offsets
  // ************************************************************
  localparam logic [7:0] OFS_ACC    = 8'h00;
  localparam logic [7:0] OFS_INDEX  = 8'h04;
  localparam logic [7:0] OFS_STACK  = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  // ************************************************************
  // commands from the decoder
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NONE      = 5'b00000,
    OP_LOAD_ACC  = 5'b00001,
    OP_STORE_ACC = 5'b00010,
    OP_ADD       = 5'b00011,
    OP_ADC       = 5'b00100,
    OP_SUB       = 5'b00101,
    OP_SBC       = 5'b00110,
    OP_AND       = 5'b00111,
    OP_OR        = 5'b01000,
    OP_XOR       = 5'b01001,
    OP_BCD       = 5'b01010,
    OP_X_CLR     = 5'b01011,
    OP_X_INC     = 5'b01100,
    OP_X_DEC     = 5'b01101,
    OP_X_COM     = 5'b01110,
    OP_X_NEG     = 5'b01111,
    OP_X_LSL     = 5'b10000,
    OP_X_LSR     = 5'b10001,
    OP_X_ROL     = 5'b10010,
    OP_X_ROR     = 5'b10011,
    OP_LOAD_X    = 5'b10100,
    OP_LOAD_H    = 5'b10101,
    OP_LOAD_HX   = 5'b10110,
    OP_HX_INC    = 5'b10111,
    OP_SPADD     = 5'b11000,
    OP_SPLOW     = 5'b11001,
    OP_PUSH      = 5'b11010,
    OP_PULL      = 5'b11011,
    OP_TAP       = 5'b11100,
    OP_ICLR      = 5'b11101,
    OP_SEI       = 5'b11110,
    OP_IRQ_MASK  = 5'b11111
  } op_t;

  typedef enum logic [1:0] {
    VS_HI  = 2'b00,
    VS_LO  = 2'b01,
    VS_RUN = 2'b10
  } vec_state_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    op_t         op;
    logic [7:0]  data;
    logic [15:0] word;
    logic        pc_step;
    logic        pc_load;
    logic [15:0] pc_target;
    logic        boundary;
  } core_req_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] index;
    logic [15:0] stack_pointer;
    logic [15:0] program_counter;
    logic [7:0]  condition_flags;
  } core_view_t;

endpackage

// file: hdl/cpu_register_file_ccr.sv
// cpu register set with condition flags, vector fetch and ahb-lite access
//
// Contract
// - reset leaves the accumulator unchanged.
// - reset forces the upper index byte to zero, lower byte kept.
// - indexed accesses use the full 16-bit index, upper byte high.
// - lower index byte clears, counts, complements, negates, shifts, rotates.
// - accumulator feeds the alu; results write back into it.
// - reset loads the stack pointer with 0x00FF.
// - stack pointer always addresses the next free stack location.
// - add-immediate-to-stack sign-extends its byte and adds to stack pointer.
// - reset-stack-low changes only the stack pointer low byte.
// - program counter steps per fetch; change-of-flow loads a new address.
// - after reset program counter loads from 0xFFFE (high) and 0xFFFF (low).
// - flag bits 6 and 5 always read one.
// - bit 7 flags two's complement overflow.
// - bit 4 flags carry from bit 3 on add and add-with-carry.
// - decimal adjust corrects the last sum using half-carry and carry.
// - mask bit 3 set blocks maskable interrupts; clear allows them.
// - interrupt entry sets the mask after stacking, before the handler.
// - no interrupt at the boundary right after an instruction clears the mask.
// - bit 2 copies the result msb for 8- and 16-bit values.
// - bit 1 set when the 8- or 16-bit result is zero.
// - bit 0 is carry out of bit 7 or borrow; shifts may set it.
`timescale 1ns/1ps

module cpu_register_file_ccr
(
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   resetn_i,
  // decoder side
  input  wire regfile_pkg::core_req_t req_i,
  input  wire logic                   irq_pending_i,
  input  wire logic [7:0]             vec_data_i,
  input  wire logic                   vec_valid_i,
  output logic                        run_o,
  output logic                        vec_req_o,
  output logic [15:0]                 vec_addr_o,
  output logic                        irq_take_o,
  output regfile_pkg::core_view_t     view_o,
  // ahb-lite slave
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  output logic [31:0]                 hrdata_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    regfile_pkg::vec_state_t vs;
    logic [7:0]              h;
    logic [15:0]             sp;
    logic [15:0]             pc;
    logic [7:0]              flags;
    logic                    block;
    logic                    irq_take;
    logic                    vec_req;
    logic [15:0]             vec_addr;
    logic                    dphase;
    logic                    bus_ok;
    logic [7:0]              bus_addr;
    logic                    bus_write;
    logic                    hready;
    logic [31:0]             hrdata;
  } st_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] x;
  } keep_t;

  st_t   st_ff;
  st_t   nxt_st;
  keep_t keep_ff;
  keep_t nxt_keep;
  logic  rst_meta_ff;
  logic  rst_sync_ff;

  // ************************************************************
  // helpers
  // ************************************************************
  // returns {overflow, half carry, carry, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       cin);
    logic [8:0] s;
    logic [4:0] lo;
    logic       v;
    s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    v  = (a[7] == b[7]) && (s[7] != a[7]);
    return {v, lo[4], s[8], s[7:0]};
  endfunction

  function automatic logic [7:0] nz8(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[regfile_pkg::FLAG_N] = r[7];
    o[regfile_pkg::FLAG_Z] = (r == 8'h00);
    return o;
  endfunction

  // ************************************************************
  // reset release
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic [10:0] sum;
    logic [7:0]  r;
    logic [7:0]  corr;
    logic        cset;
    logic        run;
    logic        sets_block;
    sum        = 11'h000;
    r          = 8'h00;
    corr       = 8'h00;
    cset       = 1'b0;
    sets_block = 1'b0;
    nxt_st     = st_ff;
    nxt_keep   = keep_ff;
    run        = (st_ff.vs == regfile_pkg::VS_RUN);

    unique case (st_ff.vs)
      regfile_pkg::VS_HI:
      begin
        if (vec_valid_i)
        begin
          nxt_st.pc[15:8] = vec_data_i;
          nxt_st.vec_addr = regfile_pkg::VEC_LO_ADDR;
          nxt_st.vs       = regfile_pkg::VS_LO;
        end
      end
      regfile_pkg::VS_LO:
      begin
        if (vec_valid_i)
        begin
          nxt_st.pc[7:0] = vec_data_i;
          nxt_st.vec_req = 1'b0;
          nxt_st.vs      = regfile_pkg::VS_RUN;
        end
      end
      regfile_pkg::VS_RUN:
      begin
        nxt_st.vec_req = 1'b0;
      end
      default:
      begin
        nxt_st.vs = regfile_pkg::VS_HI;
      end
    endcase

    if (run)
    begin
      // sequential step or change of flow
      if (req_i.pc_load)
        nxt_st.pc = req_i.pc_target;
      else if (req_i.pc_step)
        nxt_st.pc = st_ff.pc + 16'h0001;

      unique case (req_i.op)
        regfile_pkg::OP_NONE:
        begin
        end
        regfile_pkg::OP_LOAD_ACC, regfile_pkg::OP_STORE_ACC:
        begin
          r = (req_i.op == regfile_pkg::OP_LOAD_ACC) ? req_i.data : keep_ff.acc;
          nxt_keep.acc = r;
          nxt_st.flags = nz8(st_ff.flags, r);
          nxt_st.flags[regfile_pkg::FLAG_V] = 1'b0;
        end
        regfile_pkg::OP_ADD, regfile_pkg::OP_ADC, regfile_pkg::OP_SUB,
        regfile_pkg::OP_SBC:
        begin
          if (req_i.op == regfile_pkg::OP_ADD)
            sum = add8(keep_ff.acc, req_i.data, 1'b0);
          else if (req_i.op == regfile_pkg::OP_ADC)
            sum = add8(keep_ff.acc, req_i.data, st_ff.flags[regfile_pkg::FLAG_C]);
          else if (req_i.op == regfile_pkg::OP_SUB)
            sum = add8(keep_ff.acc, ~req_i.data, 1'b1);
          else
            sum = add8(keep_ff.acc, ~req_i.data, ~st_ff.flags[regfile_pkg::FLAG_C]);
          nxt_keep.acc = sum[7:0];
          nxt_st.flags = nz8(st_ff.flags, sum[7:0]);
          nxt_st.flags[regfile_pkg::FLAG_V] = sum[10];
          if (req_i.op == regfile_pkg::OP_ADD || req_i.op == regfile_pkg::OP_ADC)
          begin
            nxt_st.flags[regfile_pkg::FLAG_H] = sum[9];
            nxt_st.flags[regfile_pkg::FLAG_C] = sum[8];
          end
          else
            nxt_st.flags[regfile_pkg::FLAG_C] = ~sum[8];
        end
        // logic results back into the accumulator
        regfile_pkg::OP_AND, regfile_pkg::OP_OR, regfile_pkg::OP_XOR:
        begin
          if (req_i.op == regfile_pkg::OP_AND)
            r = keep_ff.acc & req_i.data;
          else if (req_i.op == regfile_pkg::OP_OR)
            r = keep_ff.acc | req_i.data;
          else
            r = keep_ff.acc ^ req_i.data;
          nxt_keep.acc = r;
          nxt_st.flags = nz8(st_ff.flags, r);
          nxt_st.flags[regfile_pkg::FLAG_V] = 1'b0;
        end
        regfile_pkg::OP_BCD:
        begin
          if (st_ff.flags[regfile_pkg::FLAG_C] || keep_ff.acc > 8'h99)
          begin
            corr[7:4] = 4'h6;
            cset      = 1'b1;
          end
          if (st_ff.flags[regfile_pkg::FLAG_H] || keep_ff.acc[3:0] > 4'h9)
            corr[3:0] = 4'h6;
          r = keep_ff.acc + corr;
          nxt_keep.acc = r;
          nxt_st.flags = nz8(st_ff.flags, r);
          nxt_st.flags[regfile_pkg::FLAG_C] = cset;
        end
        // lower index byte as a data register
        regfile_pkg::OP_X_CLR, regfile_pkg::OP_X_INC, regfile_pkg::OP_X_DEC,
        regfile_pkg::OP_X_COM, regfile_pkg::OP_X_NEG, regfile_pkg::OP_X_LSL,
        regfile_pkg::OP_X_LSR, regfile_pkg::OP_X_ROL, regfile_pkg::OP_X_ROR:
        begin
          cset = st_ff.flags[regfile_pkg::FLAG_C];
          unique case (req_i.op)
            regfile_pkg::OP_X_CLR: r = 8'h00;
            regfile_pkg::OP_X_INC: r = keep_ff.x + 8'h01;
            regfile_pkg::OP_X_DEC: r = keep_ff.x - 8'h01;
            regfile_pkg::OP_X_COM:
            begin
              r    = ~keep_ff.x;
              cset = 1'b1;
            end
            regfile_pkg::OP_X_NEG:
            begin
              r    = 8'h00 - keep_ff.x;
              cset = (r != 8'h00);
            end
            regfile_pkg::OP_X_LSL:
            begin
              r    = {keep_ff.x[6:0], 1'b0};
              cset = keep_ff.x[7];
            end
            regfile_pkg::OP_X_LSR:
            begin
              r    = {1'b0, keep_ff.x[7:1]};
              cset = keep_ff.x[0];
            end
            regfile_pkg::OP_X_ROL:
            begin
              r    = {keep_ff.x[6:0], st_ff.flags[regfile_pkg::FLAG_C]};
              cset = keep_ff.x[7];
            end
            default:
            begin
              r    = {st_ff.flags[regfile_pkg::FLAG_C], keep_ff.x[7:1]};
              cset = keep_ff.x[0];
            end
          endcase
          nxt_keep.x   = r;
          nxt_st.flags = nz8(st_ff.flags, r);
          nxt_st.flags[regfile_pkg::FLAG_C] = cset;
          if (req_i.op == regfile_pkg::OP_X_INC)
            nxt_st.flags[regfile_pkg::FLAG_V] = (keep_ff.x == 8'h7F);
          else if (req_i.op == regfile_pkg::OP_X_DEC || req_i.op == regfile_pkg::OP_X_NEG)
            nxt_st.flags[regfile_pkg::FLAG_V] = (keep_ff.x == 8'h80);
          else if (req_i.op == regfile_pkg::OP_X_CLR || req_i.op == regfile_pkg::OP_X_COM)
            nxt_st.flags[regfile_pkg::FLAG_V] = 1'b0;
          else
            nxt_st.flags[regfile_pkg::FLAG_V] = r[7] ^ cset;
        end
        regfile_pkg::OP_LOAD_X:
        begin
          nxt_keep.x   = req_i.data;
          nxt_st.flags = nz8(st_ff.flags, req_i.data);
          nxt_st.flags[regfile_pkg::FLAG_V] = 1'b0;
        end
        regfile_pkg::OP_LOAD_H:
        begin
          nxt_st.h = req_i.data;
        end
        regfile_pkg::OP_LOAD_HX:
        begin
          {nxt_st.h, nxt_keep.x} = req_i.word;
          nxt_st.flags[regfile_pkg::FLAG_N] = req_i.word[15];
          nxt_st.flags[regfile_pkg::FLAG_Z] = (req_i.word == 16'h0000);
          nxt_st.flags[regfile_pkg::FLAG_V] = 1'b0;
        end
        regfile_pkg::OP_HX_INC:
        begin
          {nxt_st.h, nxt_keep.x} = {st_ff.h, keep_ff.x} + 16'h0001;
        end
        regfile_pkg::OP_SPADD:
        begin
          nxt_st.sp = st_ff.sp + {{8{req_i.data[7]}}, req_i.data};
        end
        regfile_pkg::OP_SPLOW:
        begin
          nxt_st.sp[7:0] = regfile_pkg::SP_RESET[7:0];
        end
        // push writes at sp then steps down
        regfile_pkg::OP_PUSH:
        begin
          nxt_st.sp = st_ff.sp - 16'h0001;
        end
        regfile_pkg::OP_PULL:
        begin
          nxt_st.sp = st_ff.sp + 16'h0001;
        end
        regfile_pkg::OP_TAP:
        begin
          nxt_st.flags = keep_ff.acc;
          sets_block   = st_ff.flags[regfile_pkg::FLAG_I] & ~keep_ff.acc[regfile_pkg::FLAG_I];
        end
        regfile_pkg::OP_ICLR:
        begin
          nxt_st.flags[regfile_pkg::FLAG_I] = 1'b0;
          sets_block = st_ff.flags[regfile_pkg::FLAG_I];
        end
        regfile_pkg::OP_SEI:
        begin
          nxt_st.flags[regfile_pkg::FLAG_I] = 1'b1;
        end
        // mask set once stacking is done
        regfile_pkg::OP_IRQ_MASK:
        begin
          nxt_st.flags[regfile_pkg::FLAG_I] = 1'b1;
        end
      endcase

      if (sets_block)
        nxt_st.block = 1'b1;
      else if (req_i.boundary)
        nxt_st.block = 1'b0;
    end

    nxt_st.irq_take = run && req_i.boundary && irq_pending_i &&
                      !st_ff.flags[regfile_pkg::FLAG_I] && !st_ff.block;

    // ahb-lite: one wait cycle, then data phase completes
    nxt_st.hready = 1'b1;
    nxt_st.dphase = 1'b0;
    if (st_ff.dphase)
    begin
      nxt_st.hrdata = 32'h0000_0000;
      if (st_ff.bus_ok)
      begin
        unique case (st_ff.bus_addr)
          regfile_pkg::OFS_ACC:    nxt_st.hrdata[7:0]  = keep_ff.acc;
          regfile_pkg::OFS_INDEX:  nxt_st.hrdata[15:0] = {st_ff.h, keep_ff.x};
          regfile_pkg::OFS_STACK:  nxt_st.hrdata[15:0] = st_ff.sp;
          regfile_pkg::OFS_PC:     nxt_st.hrdata[15:0] = st_ff.pc;
          regfile_pkg::OFS_FLAGS:  nxt_st.hrdata[7:0]  = st_ff.flags;
          regfile_pkg::OFS_STATUS: nxt_st.hrdata[3:0]  = {st_ff.vs, st_ff.block, st_ff.irq_take};
          default:                 nxt_st.hrdata = 32'h0000_0000;
        endcase
        if (st_ff.bus_write)
        begin
          unique case (st_ff.bus_addr)
            regfile_pkg::OFS_ACC:   nxt_keep.acc = hwdata_i[7:0];
            regfile_pkg::OFS_INDEX: {nxt_st.h, nxt_keep.x} = hwdata_i[15:0];
            regfile_pkg::OFS_STACK: nxt_st.sp = hwdata_i[15:0];
            regfile_pkg::OFS_PC:    nxt_st.pc = hwdata_i[15:0];
            regfile_pkg::OFS_FLAGS: nxt_st.flags = hwdata_i[7:0];
            default:
            begin
            end
          endcase
        end
      end
    end
    else if (hsel_i && htrans_i[1] && hready_i)
    begin
      nxt_st.dphase    = 1'b1;
      nxt_st.hready    = 1'b0;
      nxt_st.bus_addr  = haddr_i[7:0];
      nxt_st.bus_write = hwrite_i;
      nxt_st.bus_ok    = (hsize_i == regfile_pkg::HSIZE_WORD) && (haddr_i[31:8] == 24'h000000);
    end

    nxt_st.flags = nxt_st.flags | regfile_pkg::FLAGS_ONES;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      st_ff          <= '0;
      st_ff.vs       <= regfile_pkg::VS_HI;
      st_ff.h        <= regfile_pkg::H_RESET;
      st_ff.sp       <= regfile_pkg::SP_RESET;
      st_ff.flags    <= regfile_pkg::FLAGS_RESET;
      st_ff.vec_req  <= 1'b1;
      st_ff.vec_addr <= regfile_pkg::VEC_HI_ADDR;
      st_ff.hready   <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // accumulator and lower index byte have no reset
  always_ff @(posedge ref_clk_i)
  begin
    keep_ff <= nxt_keep;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign run_o                       = st_ff.vs[1];
  assign vec_req_o                   = st_ff.vec_req;
  assign vec_addr_o                  = st_ff.vec_addr;
  assign irq_take_o                  = st_ff.irq_take;
  assign view_o.acc                  = keep_ff.acc;
  assign view_o.index                = {st_ff.h, keep_ff.x};
  assign view_o.stack_pointer        = st_ff.sp;
  assign view_o.program_counter      = st_ff.pc;
  assign view_o.condition_flags      = st_ff.flags;
  assign hreadyout_o                 = st_ff.hready;
  assign hresp_o                     = 1'b0;
  assign hrdata_o                    = st_ff.hrdata;

endmodule

// file: bench/regfile_properties.sv
// port assertions for the cpu register file
`timescale 1ns/1ps
module regfile_properties
(
  // watched ports
  input wire logic                    ref_clk_i,
  input wire logic                    resetn_i,
  input wire regfile_pkg::core_req_t  req_i,
  input wire logic                    irq_pending_i,
  input wire logic                    vec_valid_i,
  input wire logic                    run_o,
  input wire logic                    vec_req_o,
  input wire logic [15:0]             vec_addr_o,
  input wire logic                    irq_take_o,
  input wire regfile_pkg::core_view_t view_o,
  input wire logic                    hsel_i,
  input wire logic [1:0]              htrans_i,
  input wire logic                    hready_i,
  input wire logic                    hreadyout_o,
  input wire logic                    hresp_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_flags_ones: assert property (view_o.condition_flags[6:5] == 2'b11)
    else $error("fixed ones lost");
  a_take_cause: assert property (irq_take_o |-> $past(run_o && req_i.boundary
    && irq_pending_i && !view_o.condition_flags[3])) else $error("stray take");
  a_mask_block: assert property (run_o && req_i.op == regfile_pkg::OP_ICLR
    && view_o.condition_flags[3] |-> ##2 !irq_take_o) else $error("take after clear");
  a_push_down: assert property (run_o && req_i.op == regfile_pkg::OP_PUSH |=>
    view_o.stack_pointer == $past(view_o.stack_pointer) - 16'h0001) else $error("push");
  a_add_sign: assert property (run_o && req_i.op == regfile_pkg::OP_SPADD |=>
    view_o.stack_pointer == $past(view_o.stack_pointer)
    + {{8{$past(req_i.data[7])}}, $past(req_i.data)}) else $error("stack add");
  a_stk_low: assert property (run_o && req_i.op == regfile_pkg::OP_SPLOW |=>
    view_o.stack_pointer == {$past(view_o.stack_pointer[15:8]), 8'hFF}) else $error("low byte");
  a_pc_flow: assert property (run_o && (req_i.pc_step || req_i.pc_load) |=>
    view_o.program_counter == ($past(req_i.pc_load) ? $past(req_i.pc_target)
    : $past(view_o.program_counter) + 16'h0001)) else $error("pc update");
  a_vec_order: assert property (vec_req_o && vec_valid_i
    && vec_addr_o == regfile_pkg::VEC_HI_ADDR |=> vec_req_o
    && vec_addr_o == regfile_pkg::VEC_LO_ADDR) else $error("vector order");
  a_bus_wait: assert property (hsel_i && htrans_i[1] && hready_i |=>
    !hreadyout_o ##1 hreadyout_o && !hresp_o) else $error("bus answer");
  c_take: cover property (irq_take_o);
  c_adjust: cover property (run_o && req_i.op == regfile_pkg::OP_BCD);
  c_bus: cover property (hsel_i && htrans_i[1] && hready_i);
endmodule
bind cpu_register_file_ccr regfile_properties u_props
(
  .ref_clk_i, .resetn_i, .req_i, .irq_pending_i, .vec_valid_i, .run_o, .vec_req_o,
  .vec_addr_o, .irq_take_o, .view_o, .hsel_i, .htrans_i, .hready_i, .hreadyout_o, .hresp_o
);

// file: bench/vec_model.sv
// vector memory answering the reset vector fetch
`timescale 1ns/1ps
module vec_model
#(
  parameter logic [15:0] VECTOR = 16'h1234,
  parameter logic [7:0]  LAG    = 8'h02
)
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // fetch handshake
  input  wire logic        vec_req_i,
  input  wire logic [15:0] vec_addr_i,
  output logic [7:0]       vec_data_o,
  output logic             vec_valid_o
);
  logic [7:0] age_ff;
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      age_ff      <= 8'h00;
      vec_valid_o <= 1'b0;
    end
    else
    begin
      age_ff      <= age_ff + 8'h01;
      vec_valid_o <= vec_req_i && age_ff >= LAG && !(vec_valid_o && vec_addr_i == 16'hFFFF);
    end
  end
  assign vec_data_o = !vec_valid_o ? ~age_ff
                    : (vec_addr_i == 16'hFFFE) ? VECTOR[15:8] : VECTOR[7:0];
endmodule

// file: bench/testbench.sv
// self-checking bench for the cpu register file
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module testbench;
  logic                    ref_clk_i = 1'b0;
  logic                    resetn_i  = 1'b0;
  regfile_pkg::core_req_t  req_i     = '0;
  logic                    irq_pending_i = 1'b0;
  logic                    hsel_i    = 1'b0;
  logic [31:0]             haddr_i   = '0;
  logic [1:0]              htrans_i  = 2'b00;
  logic                    hwrite_i  = 1'b0;
  logic [31:0]             hwdata_i  = '0;
  logic [7:0]              vec_data_i;
  logic                    vec_valid_i, run_o, vec_req_o, irq_take_o, hreadyout_o, hresp_o;
  logic [15:0]             vec_addr_o;
  logic [31:0]             hrdata_o, rd;
  regfile_pkg::core_view_t view_o;
  int                      num_errors = 0;
  int                      n_compared = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  cpu_register_file_ccr u_dut
  (
    .ref_clk_i, .resetn_i, .req_i, .irq_pending_i, .vec_data_i, .vec_valid_i, .run_o,
    .vec_req_o, .vec_addr_o, .irq_take_o, .view_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i (regfile_pkg::HSIZE_WORD), .hwdata_i, .hready_i (hreadyout_o), .hreadyout_o,
    .hresp_o, .hrdata_o
  );
  vec_model u_vec
  (
    .ref_clk_i, .resetn_i, .vec_req_i (vec_req_o), .vec_addr_i (vec_addr_o),
    .vec_data_o (vec_data_i), .vec_valid_o (vec_valid_i)
  );
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    @(negedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    @(negedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(negedge ref_clk_i);
    rd = hrdata_o;
    @(posedge ref_clk_i);
  endtask
  task automatic cmd(input regfile_pkg::op_t op, input logic [15:0] w, input logic [2:0] f);
    @(posedge ref_clk_i);
    req_i <= '{op, w[7:0], w, f[0], f[1], w, f[2]};
    @(posedge ref_clk_i);
    req_i <= '0;
    @(negedge ref_clk_i);
  endtask
  task automatic do_reset;
    resetn_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 30 && run_o !== 1'b1; i++) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK(run_o, 1'b1)
    `CHK(view_o.program_counter, 16'h1234)
    `CHK(view_o.stack_pointer, regfile_pkg::SP_RESET)
    `CHK(view_o.index[15:8], regfile_pkg::H_RESET)
  endtask
  task automatic t_boot;
    do_reset();
    `CHK(view_o.condition_flags, regfile_pkg::FLAGS_RESET)
  endtask
  task automatic t_alu;
    cmd(regfile_pkg::OP_LOAD_ACC, 16'h007F, 3'b000);
    cmd(regfile_pkg::OP_ADD, 16'h0001, 3'b000);
    `CHK(view_o.acc, 8'h80)
    `CHK(view_o.condition_flags, 8'hFC)
    cmd(regfile_pkg::OP_LOAD_ACC, 16'h0099, 3'b000);
    cmd(regfile_pkg::OP_ADD, 16'h0001, 3'b000);
    cmd(regfile_pkg::OP_BCD, 16'h0000, 3'b000);
    `CHK(view_o.acc, 8'h00)
    `CHK(view_o.condition_flags[1:0], 2'b11)
  endtask
  task automatic t_index;
    cmd(regfile_pkg::OP_LOAD_HX, 16'h12FF, 3'b000);
    `CHK(view_o.index, 16'h12FF)
    cmd(regfile_pkg::OP_X_INC, 16'h0000, 3'b000);
    `CHK(view_o.index, 16'h1200)
    `CHK(view_o.condition_flags[1], 1'b1)
    cmd(regfile_pkg::OP_X_COM, 16'h0000, 3'b000);
    `CHK(view_o.index, 16'h12FF)
  endtask
  task automatic t_stack;
    ahb(1'b1, regfile_pkg::OFS_STACK, 32'h0000_1234);
    cmd(regfile_pkg::OP_SPADD, 16'h00FE, 3'b000);
    `CHK(view_o.stack_pointer, 16'h1232)
    cmd(regfile_pkg::OP_SPLOW, 16'h0000, 3'b000);
    `CHK(view_o.stack_pointer, 16'h12FF)
    cmd(regfile_pkg::OP_PUSH, 16'h0000, 3'b000);
    ahb(1'b0, regfile_pkg::OFS_STACK, 32'h0);
    `CHK(rd, 32'h0000_12FE)
  endtask
  task automatic t_pc;
    cmd(regfile_pkg::OP_NONE, 16'h0000, 3'b001);
    `CHK(view_o.program_counter, 16'h1235)
    cmd(regfile_pkg::OP_NONE, 16'hABCD, 3'b011);
    `CHK(view_o.program_counter, 16'hABCD)
  endtask
  task automatic t_irq;
    @(posedge ref_clk_i);
    irq_pending_i <= 1'b1;
    cmd(regfile_pkg::OP_NONE, 16'h0000, 3'b100);
    `CHK(irq_take_o, 1'b0)
    @(posedge ref_clk_i);
    req_i.op <= regfile_pkg::OP_ICLR;
    @(posedge ref_clk_i);
    req_i.op <= regfile_pkg::OP_NONE;
    req_i.boundary <= 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK(irq_take_o, 1'b0)
    @(negedge ref_clk_i);
    `CHK(irq_take_o, 1'b1)
    @(posedge ref_clk_i);
    req_i <= '0;
    irq_pending_i <= 1'b0;
    cmd(regfile_pkg::OP_IRQ_MASK, 16'h0000, 3'b000);
    `CHK(view_o.condition_flags[regfile_pkg::FLAG_I], 1'b1)
  endtask
  task automatic t_bus;
    ahb(1'b1, regfile_pkg::OFS_FLAGS, 32'h0);
    ahb(1'b0, regfile_pkg::OFS_FLAGS, 32'h0);
    `CHK(rd, 32'h0000_0060)
    ahb(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, regfile_pkg::OFS_ACC, 32'h0000_005A);
    ahb(1'b0, regfile_pkg::OFS_ACC, 32'h0);
    `CHK(rd, 32'h0000_005A)
  endtask
  task automatic t_rerun;
    do_reset();
    `CHK(view_o.acc, 8'h5A)
    `CHK(view_o.index, 16'h00FF)
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    t_boot();
    t_alu();
    t_index();
    t_stack();
    t_pc();
    t_irq();
    t_bus();
    t_rerun();
    report_and_stop();
  end
endmodule
